/* ssm_checker.sv */
// Port checker of the supply sequencer and monitor
`include "ssm_defines.svh"
module ssm_checker #(
    parameter int NCH = 5,
    parameter int MIN_PW_CYC = 16,
    parameter int RST_LONG_CYC = 32000000
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [`SSM_ADDR_W-1:0] paddr_i,
    input wire logic pslverr_o,
    input wire logic analog_enable_i,
    input wire logic power_down_request_n_i,
    input wire logic [NCH-1:0] overvoltage_above_i,
    input wire logic [NCH-1:0] supply_enable_o,
    input wire logic [NCH-1:0] discharge_on_o,
    input wire logic fault_line_oe_n_o,
    input wire logic reset_n_o,
    input wire logic overvoltage_flag_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] lo_cnt;
    logic [7:0] en_cnt;
    // Not saturating: at 1024 cycles of fault-line drive the count wraps to zero, back under the bound
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) lo_cnt <= '0;
        else lo_cnt <= fault_line_oe_n_o ? 10'h0 : lo_cnt + 10'h1;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) en_cnt <= '0;
        else en_cnt <= analog_enable_i ? 8'h0 : (en_cnt == 8'hff ? en_cnt : en_cnt + 8'h1);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_enable_low_off: assert property (en_cnt > MIN_PW_CYC + 6 && power_down_request_n_i |-> supply_enable_o == '0)
        else $error("enables up while analog enable low");
    a_fault_drops_all: assert property ($fell(fault_line_oe_n_o) |-> supply_enable_o == '0)
        else $error("fault pulse with enables up");
    a_fault_width: assert property ($rose(fault_line_oe_n_o) |-> lo_cnt >= `SSM_FAULT_PW_CYC)
        else $error("fault pulse too short");
    a_fault_resets: assert property (!fault_line_oe_n_o |-> !reset_n_o && discharge_on_o != '0)
        else $error("fault without reset or discharge");
    a_single_release: assert property ($countones(supply_enable_o & ~$past(supply_enable_o)) <= 1)
        else $error("two enables released together");
    a_down_one_drop: assert property ($countones($past(supply_enable_o) & ~supply_enable_o) > 1 |-> supply_enable_o == '0)
        else $error("partial multi-drop");
    a_ov_set: assert property (overvoltage_above_i != '0 [*4] |-> !overvoltage_flag_n_o)
        else $error("overvoltage flag not set");
    a_ov_clear: assert property (overvoltage_above_i == '0 [*4] |-> overvoltage_flag_n_o)
        else $error("overvoltage flag not released");
    a_reset_cause_gone: assert property ($rose(reset_n_o) |-> $past(power_down_request_n_i, 4) && $past(analog_enable_i, 4))
        else $error("reset released with cause present");
    a_unmapped_err: assert property (psel_i && penable_i && paddr_i >= 12'h010 |-> pslverr_o)
        else $error("unmapped access without error");
    c_fault: cover property ($fell(fault_line_oe_n_o));
    c_reset_done: cover property ($rose(reset_n_o));
    c_bus_err: cover property (pslverr_o);
endmodule : ssm_checker

bind ssm_top ssm_checker #(.NCH(NCH), .MIN_PW_CYC(MIN_PW_CYC), .RST_LONG_CYC(RST_LONG_CYC)) chk_u (.*);

/* ssm_defines.svh */
// Constants of the supply sequencer and monitor
`ifndef SSM_DEFINES_SVH
`define SSM_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSM_CLK_PERIOD_NS 4
`define SSM_SEQ_DELAY_NS 10000
`define SSM_SEQ_DELAY_CYC ((`SSM_SEQ_DELAY_NS + `SSM_CLK_PERIOD_NS - 1) / `SSM_CLK_PERIOD_NS)
`define SSM_FAULT_PW_NS 1900
`define SSM_FAULT_PW_CYC ((`SSM_FAULT_PW_NS + `SSM_CLK_PERIOD_NS - 1) / `SSM_CLK_PERIOD_NS)
`define SSM_RST_SHORT_NS 10000
`define SSM_RST_SHORT_CYC ((`SSM_RST_SHORT_NS + `SSM_CLK_PERIOD_NS - 1) / `SSM_CLK_PERIOD_NS)
`define SSM_RST_LONG_MS 128
`define SSM_RST_LONG_CYC (`SSM_RST_LONG_MS * 1000000 / `SSM_CLK_PERIOD_NS)
`define SSM_MIN_PW_CYC 16

// ----------------------------------------------------------------
// Order select
// ----------------------------------------------------------------
`define SSM_TRI_OPEN 2'h0
`define SSM_TRI_LOW 2'h1
`define SSM_TRI_HIGH 2'h2
`define SSM_SEL_W1 9
`define SSM_SEL_W2 3
`define SSM_NUM_ORDERS 24

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SSM_ADDR_W 12
`define SSM_OFF_CTRL 12'h000
`define SSM_OFF_SEQ_DELAY 12'h004
`define SSM_OFF_RST_TIMEOUT 12'h008
`define SSM_OFF_STATUS 12'h00c
`define SSM_CTRL_RST 32'h0000_0000
`define SSM_SEQ_DELAY_RST 32'h0000_09c4
`define SSM_RST_TIMEOUT_RST 32'h0000_09c4
`define SSM_CTRL_FIVE_BIT 0
`define SSM_ST_STATE_LSB 0
`define SSM_ST_STEP_LSB 4
`define SSM_ST_EN_LSB 8
`define SSM_ST_DISCHARGE_SENSE_LSB 16
`define SSM_ST_RESET_BIT 24
`define SSM_ST_OV_BIT 25
`define SSM_ST_REM_BIT 26
`define SSM_ST_FAULT_BIT 27

`endif

/* ssm_lowfilt.sv */
// Low-pulse width filter: a low is passed only after MIN_PW cycles
module ssm_lowfilt #(
    parameter int MIN_PW = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic d_i,
    output logic q_o
);
    localparam int CW = $clog2(MIN_PW + 1);
    localparam logic [CW-1:0] LAST = CW'(MIN_PW - 1);
    logic [CW-1:0] cnt_reg;

    // Reset value low: treat everything as not yet valid
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= '0;
            q_o <= 1'b0;
        end else if (ce_i) begin
            if (d_i) begin
                cnt_reg <= '0;
                q_o <= 1'b1;
            end else if (cnt_reg == LAST) begin
                q_o <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg + CW'(1);
            end
        end
    end
endmodule : ssm_lowfilt

/* ssm_pkg.sv */
// Types of the supply sequencer and monitor
package ssm_pkg;
    typedef logic [1:0] ssm_tri_t;
    typedef logic [2:0] ssm_chan_t;
    typedef enum logic [2:0] {
        ST_WAIT = 3'h0,
        ST_UP_WAIT = 3'h1,
        ST_UP_DELAY = 3'h3,
        ST_ON = 3'h2,
        ST_DOWN = 3'h6,
        ST_FAULT = 3'h7,
        ST_DRAIN = 3'h5
    } ssm_state_t;
endpackage : ssm_pkg

/* ssm_rail_model.sv */
// Behavioural model of five converters seen through their comparators
module ssm_rail_model (
    input wire logic clk_i,
    input wire logic [4:0] en_i,
    input wire logic [4:0] drop_i,
    output logic [4:0] thr_o,
    output logic [4:0] dis_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] up [5] = '{default: 6'h0};
    logic [5:0] dn [5] = '{default: 6'h0};
    // Rails ramp at one rate but cross their thresholds at different levels; output decays 32 cycles after disable
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < 5; k++) begin
            up[k] <= en_i[k] ? (up[k] == 6'h3f ? up[k] : up[k] + 6'h1) : 6'h0;
            dn[k] <= en_i[k] ? 6'h20 : (dn[k] != 6'h0 ? dn[k] - 6'h1 : 6'h0);
        end
    end
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            thr_o[k] = int'(up[k]) > 4 + 8 * k && !drop_i[k];
            dis_o[k] = dn[k] != 6'h0;
        end
    end
endmodule : ssm_rail_model

/* ssm_sync.sv */
// Two-flop synchroniser for a group of pin inputs
module ssm_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else if (ce_i) begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : ssm_sync

/* ssm_top.sv */
// Supply sequencer and monitor: start-up, order, fault, power-down, reset, APB
`include "ssm_defines.svh"
module ssm_top #(
    parameter int NCH = 5,
    parameter int MIN_PW_CYC = `SSM_MIN_PW_CYC,
    parameter int RST_LONG_CYC = `SSM_RST_LONG_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [`SSM_ADDR_W-1:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic internal_supply_rail_ok_i,
    input wire logic analog_enable_i,
    input wire logic power_down_request_n_i,
    input wire logic reverse_hold_i,
    input wire logic [NCH-1:0] threshold_above_i,
    input wire logic [NCH-1:0] overvoltage_above_i,
    input wire logic [NCH-1:0] discharge_sense_high_i,
    input wire ssm_pkg::ssm_tri_t order_select_first_i,
    input wire ssm_pkg::ssm_tri_t order_select_second_i,
    input wire ssm_pkg::ssm_tri_t order_select_third_i,
    input wire ssm_pkg::ssm_tri_t timeout_select_i,
    input wire logic delay_cap_fitted_i,
    input wire logic fault_line_i,
    output logic fault_line_o,
    output logic fault_line_oe_n_o,
    output logic [NCH-1:0] supply_enable_o,
    output logic [NCH-1:0] discharge_on_o,
    output logic reset_n_o,
    output logic overvoltage_flag_n_o,
    output logic bus_removal_flag_n_o
);
    import ssm_pkg::*;

    localparam int SW = 3 * NCH + 12;
    localparam logic [2:0] N_SEL = 3'h4;
    localparam logic [2:0] N_FIX = 3'(NCH);

    // ----------------------------------------------------------------
    // Pin synchronisation and pulse filters
    // ----------------------------------------------------------------
    logic [SW-1:0] sync_q;
    logic s_rail, s_en, s_pdr_n, s_hold, s_dcap, s_fault;
    logic [NCH-1:0] s_thr, s_ov, s_discharge_sense;
    ssm_tri_t s_sel1, s_sel2, s_sel3, s_tmo;
    logic en_ok, pdr_n, fault_n;

    ssm_sync #(.W(SW)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .d_i({internal_supply_rail_ok_i, analog_enable_i, power_down_request_n_i, reverse_hold_i,
              delay_cap_fitted_i, fault_line_i, threshold_above_i, overvoltage_above_i,
              discharge_sense_high_i, order_select_first_i, order_select_second_i,
              order_select_third_i}),
        .q_o(sync_q)
    );
    ssm_sync #(.W(2)) u_sync_tmo (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .d_i(timeout_select_i),
        .q_o(s_tmo)
    );
    assign {s_rail, s_en, s_pdr_n, s_hold, s_dcap, s_fault, s_thr, s_ov, s_discharge_sense, s_sel1, s_sel2, s_sel3} = sync_q;

    ssm_lowfilt #(.MIN_PW(MIN_PW_CYC)) u_filt_en (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .d_i(s_en),
        .q_o(en_ok)
    );
    ssm_lowfilt #(.MIN_PW(MIN_PW_CYC)) u_filt_pdr (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .d_i(s_pdr_n),
        .q_o(pdr_n)
    );
    ssm_lowfilt #(.MIN_PW(MIN_PW_CYC)) u_filt_fault (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .d_i(s_fault),
        .q_o(fault_n)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg, seq_delay_reg, rst_timeout_reg;
    logic five_ch;
    logic [NCH-1:0] act_mask;
    logic [2:0] n_act;

    assign five_ch = ctrl_reg[`SSM_CTRL_FIVE_BIT];
    assign n_act = five_ch ? N_FIX : N_SEL;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            act_mask[i] = (3'(i) < n_act);
        end
    end

    // ----------------------------------------------------------------
    // Order selection
    // ----------------------------------------------------------------
    // Lexicographic permutation of channels 0..3 for index 0..23
    function automatic logic [11:0] perm4(input int idx);
        ssm_chan_t pool [4];
        logic [11:0] res;
        int k, r;
        for (int p = 0; p < 4; p++) begin
            pool[p] = 3'(p);
        end
        res = '0;
        r = idx;
        for (int p = 0; p < 4; p++) begin
            k = (p == 0) ? r / 6 : (p == 1) ? r / 2 : (p == 2) ? r : 0;
            r = (p == 0) ? r % 6 : (p == 1) ? r % 2 : 0;
            res[3*p +: 3] = pool[k];
            for (int j = 0; j < 3; j++) begin
                if (j >= k) begin
                    pool[j] = pool[j+1];
                end
            end
        end
        return res;
    endfunction : perm4

    int sel_idx;
    ssm_chan_t ord_sel [NCH];
    logic [11:0] perm_bits;

    always_comb begin
        sel_idx = int'(s_sel1) * `SSM_SEL_W1 + int'(s_sel2) * `SSM_SEL_W2 + int'(s_sel3);
        // Out-of-range codes fall back to the ascending order
        if (sel_idx >= `SSM_NUM_ORDERS) begin
            sel_idx = 0;
        end
        perm_bits = perm4(sel_idx);
        for (int i = 0; i < NCH; i++) begin
            if (five_ch || i >= 4) begin
                ord_sel[i] = 3'(i);
            end else begin
                ord_sel[i] = perm_bits[3*i +: 3];
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer state machine
    // ----------------------------------------------------------------
    ssm_state_t state_reg;
    ssm_chan_t ord_reg [NCH];
    ssm_chan_t last_reg;
    logic [2:0] step_reg;
    logic [31:0] tmr_reg;
    logic [NCH-1:0] en_reg;
    logic start_ok, discharge_sense_all_low, thr_low, last_up;
    logic [31:0] delay_load;

    assign discharge_sense_all_low = ~|(s_discharge_sense & act_mask);
    assign start_ok = s_rail & en_ok & pdr_n & discharge_sense_all_low & fault_n;
    assign thr_low = |(~s_thr & act_mask);
    assign last_up = s_thr[ord_reg[step_reg - 3'h1]];
    // Capacitor delay comes from software; timer ends when it reaches zero
    assign delay_load = s_dcap ? ((seq_delay_reg == '0) ? '0 : seq_delay_reg - 32'h1)
                               : 32'(`SSM_SEQ_DELAY_CYC - 1);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_WAIT;
            step_reg <= '0;
            last_reg <= '0;
            tmr_reg <= '0;
            en_reg <= '0;
            for (int i = 0; i < NCH; i++) begin
                ord_reg[i] <= '0;
            end
        end else if (ce_i) begin
            unique case (state_reg)
                ST_WAIT: begin
                    en_reg <= '0;
                    if (start_ok) begin
                        ord_reg <= ord_sel;
                        en_reg[ord_sel[0]] <= 1'b1;
                        step_reg <= 3'h1;
                        state_reg <= ST_UP_WAIT;
                    end
                end
                ST_UP_WAIT, ST_UP_DELAY, ST_ON: begin
                    if (!en_ok) begin
                        en_reg <= '0;
                        state_reg <= ST_DRAIN;
                    end else if (!fault_n) begin
                        en_reg <= '0;
                        tmr_reg <= 32'(`SSM_FAULT_PW_CYC - 1);
                        state_reg <= ST_FAULT;
                    end else if (!pdr_n && s_hold) begin
                        en_reg[ord_reg[step_reg - 3'h1]] <= 1'b0;
                        last_reg <= ord_reg[step_reg - 3'h1];
                        step_reg <= step_reg - 3'h1;
                        state_reg <= ST_DOWN;
                    end else if (state_reg == ST_ON) begin
                        if (thr_low) begin
                            en_reg <= '0;
                            tmr_reg <= 32'(`SSM_FAULT_PW_CYC - 1);
                            state_reg <= ST_FAULT;
                        end
                    end else if (state_reg == ST_UP_WAIT) begin
                        // No timeout here: a rail that never rises stalls forever
                        if (last_up) begin
                            if (step_reg == n_act) begin
                                state_reg <= ST_ON;
                            end else begin
                                tmr_reg <= delay_load;
                                state_reg <= ST_UP_DELAY;
                            end
                        end
                    end else begin
                        if (tmr_reg == '0) begin
                            en_reg[ord_reg[step_reg]] <= 1'b1;
                            step_reg <= step_reg + 3'h1;
                            state_reg <= ST_UP_WAIT;
                        end else begin
                            tmr_reg <= tmr_reg - 32'h1;
                        end
                    end
                end
                ST_DOWN: begin
                    // Enable loss is ignored once reverse power-down has begun
                    if (!fault_n) begin
                        en_reg <= '0;
                        tmr_reg <= 32'(`SSM_FAULT_PW_CYC - 1);
                        state_reg <= ST_FAULT;
                    end else if (!s_discharge_sense[last_reg]) begin
                        if (step_reg == '0) begin
                            state_reg <= ST_DRAIN;
                        end else begin
                            en_reg[ord_reg[step_reg - 3'h1]] <= 1'b0;
                            last_reg <= ord_reg[step_reg - 3'h1];
                            step_reg <= step_reg - 3'h1;
                        end
                    end
                end
                ST_FAULT: begin
                    en_reg <= '0;
                    if (tmr_reg == '0) begin
                        state_reg <= ST_DRAIN;
                    end else begin
                        tmr_reg <= tmr_reg - 32'h1;
                    end
                end
                ST_DRAIN: begin
                    en_reg <= '0;
                    step_reg <= '0;
                    if (discharge_sense_all_low) begin
                        state_reg <= ST_WAIT;
                    end
                end
                default: begin
                    en_reg <= '0;
                    state_reg <= ST_WAIT;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers: discharge, fault line, flags
    // ----------------------------------------------------------------
    logic discharge_sense_on_reg, fault_drv_reg, ov_n_reg, rem_n_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            discharge_sense_on_reg <= 1'b0;
            fault_drv_reg <= 1'b0;
            ov_n_reg <= 1'b1;
            rem_n_reg <= 1'b1;
        end else if (ce_i) begin
            discharge_sense_on_reg <= (state_reg == ST_FAULT) || (state_reg == ST_DOWN) || (state_reg == ST_DRAIN);
            fault_drv_reg <= (state_reg == ST_FAULT) && en_ok && pdr_n;
            ov_n_reg <= ~|(s_ov & act_mask);
            rem_n_reg <= ~|(s_discharge_sense & act_mask);
        end
    end

    assign supply_enable_o = en_reg;
    assign discharge_on_o = {NCH{discharge_sense_on_reg}} & act_mask;
    assign fault_line_o = 1'b0;
    assign fault_line_oe_n_o = ~fault_drv_reg;
    assign overvoltage_flag_n_o = ov_n_reg;
    assign bus_removal_flag_n_o = rem_n_reg;

    // ----------------------------------------------------------------
    // Reset output and timeout
    // ----------------------------------------------------------------
    logic rst_cause, rst_n_reg;
    logic [31:0] rst_cnt_reg, rst_load;

    assign rst_cause = (state_reg != ST_ON) || thr_low || !s_rail || !en_ok || !pdr_n || !fault_n;
    always_comb begin
        unique case (s_tmo)
            `SSM_TRI_HIGH: rst_load = 32'(RST_LONG_CYC);
            `SSM_TRI_OPEN: rst_load = 32'(`SSM_RST_SHORT_CYC);
            default: rst_load = rst_timeout_reg;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_cnt_reg <= '0;
            rst_n_reg <= 1'b0;
        end else if (ce_i) begin
            if (rst_cause) begin
                rst_cnt_reg <= rst_load;
                rst_n_reg <= 1'b0;
            end else if (rst_cnt_reg != '0) begin
                rst_cnt_reg <= rst_cnt_reg - 32'h1;
            end else begin
                rst_n_reg <= 1'b1;
            end
        end
    end
    assign reset_n_o = rst_n_reg;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    logic wr_acc, setup, map_hit;
    logic [31:0] rd_val, status_val;

    assign pready_o = ce_i;
    assign setup = psel_i && !penable_i && ce_i;
    assign wr_acc = psel_i && penable_i && pwrite_i && ce_i && map_hit;
    assign map_hit = (paddr_i == `SSM_OFF_CTRL) || (paddr_i == `SSM_OFF_SEQ_DELAY)
                   || (paddr_i == `SSM_OFF_RST_TIMEOUT) || (paddr_i == `SSM_OFF_STATUS);
    assign pslverr_o = psel_i && penable_i && !map_hit;

    always_comb begin
        status_val = '0;
        status_val[`SSM_ST_STATE_LSB +: 3] = state_reg;
        status_val[`SSM_ST_STEP_LSB +: 3] = step_reg;
        status_val[`SSM_ST_EN_LSB +: NCH] = en_reg;
        status_val[`SSM_ST_DISCHARGE_SENSE_LSB +: NCH] = s_discharge_sense;
        status_val[`SSM_ST_RESET_BIT] = rst_n_reg;
        status_val[`SSM_ST_OV_BIT] = ov_n_reg;
        status_val[`SSM_ST_REM_BIT] = rem_n_reg;
        status_val[`SSM_ST_FAULT_BIT] = fault_n;
        unique case (paddr_i)
            `SSM_OFF_CTRL: rd_val = ctrl_reg;
            `SSM_OFF_SEQ_DELAY: rd_val = seq_delay_reg;
            `SSM_OFF_RST_TIMEOUT: rd_val = rst_timeout_reg;
            `SSM_OFF_STATUS: rd_val = status_val;
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= '0;
        end else if (setup) begin
            prdata_o <= rd_val;
        end
    end

    // Variant changes take effect at once; only the channel order is latched at the next start
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= `SSM_CTRL_RST;
            seq_delay_reg <= `SSM_SEQ_DELAY_RST;
            rst_timeout_reg <= `SSM_RST_TIMEOUT_RST;
        end else if (wr_acc) begin
            if (paddr_i == `SSM_OFF_CTRL) begin
                ctrl_reg <= {31'h0, pwdata_i[`SSM_CTRL_FIVE_BIT]};
            end
            if (paddr_i == `SSM_OFF_SEQ_DELAY) begin
                seq_delay_reg <= pwdata_i;
            end
            if (paddr_i == `SSM_OFF_RST_TIMEOUT) begin
                rst_timeout_reg <= pwdata_i;
            end
        end
    end
endmodule : ssm_top

/* supply_sequencer_monitor_tb.sv */
// Self-checking bench of the supply sequencer and monitor
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module supply_sequencer_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ssm_pkg::*;
    logic clk_i = 0, rstn_i = 0, psel = 0, pen = 0, pwr = 0, en = 0, power_down_request_n = 1, hold = 1, cap = 0, ext = 1;
    logic rail = 0;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, prd, r;
    logic prdy, perr, e, foe, fo, rn, ovf, remf, fl;
    ssm_tri_t s1 = 0, s2 = 0, s3 = 0, tsel = 0;
    logic [4:0] ov = 0, drop = 0, thr, dis, sen, don;
    int error_cnt = 0, n_tests = 0;
    assign fl = foe ? ext : fo;
    ssm_top #(.MIN_PW_CYC(4), .RST_LONG_CYC(200)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .paddr_i(pa), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .internal_supply_rail_ok_i(rail), .analog_enable_i(en),
        .power_down_request_n_i(power_down_request_n), .reverse_hold_i(hold), .threshold_above_i(thr),
        .overvoltage_above_i(ov), .discharge_sense_high_i(dis), .order_select_first_i(s1),
        .order_select_second_i(s2), .order_select_third_i(s3), .timeout_select_i(tsel),
        .delay_cap_fitted_i(cap), .fault_line_i(fl), .fault_line_o(fo), .fault_line_oe_n_o(foe),
        .supply_enable_o(sen), .discharge_on_o(don), .reset_n_o(rn), .overvoltage_flag_n_o(ovf),
        .bus_removal_flag_n_o(remf));
    ssm_rail_model rail_u (.clk_i(clk_i), .en_i(sen), .drop_i(drop), .thr_o(thr), .dis_o(dis));
    initial forever #2 clk_i = ~clk_i;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic tmo(input int t, input int lim);
        if (t >= lim) begin
            error_cnt++;
            give_verdict();
        end
    endtask : tmo
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        psel <= 1; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk_i);
        pen <= 1;
        t = 0;
        do begin @(posedge clk_i); t++; end while (prdy !== 1'b1 && t < 50);
        tmo(t, 50);
        r = prd;
        e = perr;
        psel <= 0; pen <= 0;
        @(posedge clk_i);
    endtask : apb
    task automatic wait_en(input logic [4:0] old, input int lim, output int t);
        t = 0;
        while (sen === old && t < lim) begin @(posedge clk_i); t++; end
        tmo(t, lim);
    endtask : wait_en
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic up(input logic [19:0] ord, input int n, input int d, input int rmin);
        logic [4:0] x;
        int t;
        x = 0;
        for (int i = 0; i < n; i++) begin
            wait_en(x, 9000, t);
            if (i > 0) `CHK(t > d, 1'b1)
            x[ord[4*i+:3]] = 1;
            `CHK(sen, x)
        end
        t = 0;
        while (rn !== 1'b1 && t < 9000) begin @(posedge clk_i); t++; end
        tmo(t, 9000);
        `CHK(t >= rmin, 1'b1)
        `CHK(remf, 1'b0)
        `CHK(don, 5'h00)
    endtask : up
    task automatic flt(input int ch, input logic [4:0] dexp);
        int t;
        if (ch < 0) ext <= 0;
        else drop[ch] <= 1;
        wait_en(sen, 60, t);
        `CHK(sen, 5'h00)
        repeat (2) @(posedge clk_i);
        if (ch >= 0) `CHK(foe, 1'b0)
        `CHK(don, dexp)
        `CHK(rn, 1'b0)
        drop <= 0; ext <= 1;
    endtask : flt
    task automatic down(input logic [19:0] ord, input int n);
        logic [4:0] x;
        int t;
        x = sen;
        hold <= 0; power_down_request_n <= 0;
        repeat (40) @(posedge clk_i);
        `CHK(sen, x)
        `CHK(rn, 1'b0)
        hold <= 1;
        for (int i = n - 1; i >= 0; i--) begin
            wait_en(x, 500, t);
            if (i < n - 1) `CHK(dis[ord[4*i+4+:3]], 1'b0)
            if (i < n - 1) `CHK(t < 60, 1'b1)
            x[ord[4*i+:3]] = 0;
            `CHK(sen, x)
            // Pulldown control is registered from the state, one edge behind the first drop
            @(posedge clk_i);
            `CHK(don != 0, 1'b1)
        end
        power_down_request_n <= 1;
    endtask : down
    initial begin
        int t;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1;
        @(posedge clk_i);
        apb(0, 12'h000, 0); `CHK(r, 32'h0000_0000)
        apb(0, 12'h008, 0); `CHK(r, 32'h0000_09c4)
        apb(1, 12'h004, 300); apb(0, 12'h004, 0); `CHK(r, 32'h0000_012c)
        apb(0, 12'h010, 0); `CHK({e, r}, 33'h1_0000_0000)
        ov <= 5'h04; repeat (5) @(posedge clk_i); `CHK(ovf, 1'b0)
        ov <= 5'h00; repeat (5) @(posedge clk_i); `CHK(ovf, 1'b1)
        `CHK(sen, 5'h00)
        apb(1, 12'h000, 1);
        en <= 1;
        repeat (20) @(posedge clk_i);
        `CHK(sen, 5'h00)
        rail <= 1;
        up(20'h43210, 5, 2500, 2500);
        flt(2, 5'h1f);
        apb(1, 12'h000, 0);
        cap <= 1; tsel <= 2; s1 <= 2; s2 <= 1; s3 <= 2;
        up(20'h00123, 4, 300, 200);
        down(20'h00123, 4);
        s1 <= 1; s2 <= 0; s3 <= 1; tsel <= 1;
        up(20'h02031, 4, 300, 2500);
        flt(-1, 5'h0f);
        s1 <= 0; s2 <= 0; s3 <= 0;
        up(20'h03210, 4, 300, 2500);
        en <= 0;
        wait_en(sen, 60, t);
        `CHK(sen, 5'h00)
        `CHK(rn, 1'b0)
        repeat (40) @(posedge clk_i);
        `CHK(remf, 1'b1)
        give_verdict();
    end
endmodule : supply_sequencer_monitor_tb
